// ---- rtl/ned_pkg.sv ----
// constants and carrier types for the numeric escape decoder
// assumes a single 40 MHz clock domain
package ned_pkg;

   // ****************************************
   // escape prefix and field encodings
   // ****************************************
   localparam logic [4:0] ESC_PREFIX   = 5'h1B;
   localparam logic [7:0] HOST_WAIT_OP = 8'h9B;

   localparam logic [1:0] MF_REAL32  = 2'h0;
   localparam logic [1:0] MF_INT32   = 2'h1;
   localparam logic [1:0] MF_REAL64  = 2'h2;
   localparam logic [1:0] MF_INT16   = 2'h3;

   localparam logic [1:0] MOD_NODISP = 2'h0;
   localparam logic [1:0] MOD_DISP8  = 2'h1;
   localparam logic [1:0] MOD_DISP16 = 2'h2;
   localparam logic [1:0] MOD_REG    = 2'h3;
   localparam logic [2:0] RM_DIRECT  = 3'h6;

   // ****************************************
   // timing counts in clocks and the clock rate in MHz
   // ****************************************
   localparam logic [10:0] POP_EXTRA   = 11'h005;
   localparam logic [10:0] WAIT_BASE   = 11'h003;
   localparam logic [10:0] WAIT_PASS   = 11'h005;
   localparam int          CLK_MHZ     = 40;

   // ****************************************
   // operation codes
   // ****************************************
   typedef enum logic [5:0] {
      OP_NONE = 6'h00, OP_LDZ = 6'h01, OP_LD1 = 6'h02, OP_LDPI = 6'h03,
      OP_LDL2T = 6'h04, OP_LDL2E = 6'h05, OP_LDLG2 = 6'h06, OP_LDLN2 = 6'h07,
      OP_ADD = 6'h08, OP_SUB = 6'h09, OP_MUL = 6'h0A, OP_DIV = 6'h0B,
      OP_SQRT = 6'h0C, OP_SCALE = 6'h0D, OP_PREM = 6'h0E, OP_RND = 6'h0F,
      OP_XTRACT = 6'h10, OP_ABS = 6'h11, OP_CHS = 6'h12, OP_PTAN = 6'h13,
      OP_PATAN = 6'h14, OP_EXP2M1 = 6'h15, OP_YL2X = 6'h16, OP_YL2XP1 = 6'h17,
      OP_INIT = 6'h18, OP_IRQON = 6'h19, OP_IRQOFF = 6'h1A, OP_CLEX = 6'h1B,
      OP_LDCW = 6'h1C, OP_STCW = 6'h1D, OP_STSW = 6'h1E, OP_STENV = 6'h1F,
      OP_LDENV = 6'h20, OP_SAVE = 6'h21, OP_RSTOR = 6'h22, OP_INCSP = 6'h23,
      OP_DECSP = 6'h24, OP_FREE = 6'h25, OP_IDLE = 6'h26
   } ned_op_t;

   typedef struct packed {
      ned_op_t     op;
      logic [1:0]  mem_format;
      logic        dest_below;
      logic        pop;
      logic        reversed;
      logic        mem_operand;
      logic [2:0]  stack_index;
      logic [15:0] location;
      logic [10:0] min_clocks;
      logic [10:0] max_clocks;
      logic        adds_ea;
   } ned_dec_t;

   typedef struct packed {
      logic [15:0] bx;
      logic [15:0] bp;
      logic [15:0] si;
      logic [15:0] di;
   } ned_regs_t;

endpackage

// ---- rtl/ned_busy_timer.sv ----
// busy timer: holds busy for a clock count and counts host sampling passes
// assumes start pulses come from the decoder on the same clock
`timescale 1ns/10ps
module ned_busy_timer
   import ned_pkg::*;
#(
   parameter int CNT_W = 11
) (
   input  wire logic             clk_i,
   input  wire logic             arst_n_i,
   input  wire logic             start_i,
   input  wire logic [CNT_W-1:0] clocks_i,
   input  wire logic             sample_i,
   output logic                  busy_o,
   output logic [15:0]           wait_cost_o
);

   if (CNT_W < 11) begin : g_width_check
      $error("count width too small");
   end

   logic [CNT_W-1:0] remain_ff;
   logic [CNT_W-1:0] nxt_remain;
   logic [15:0]      cost_ff;
   logic [15:0]      nxt_cost;
   logic             busy_ff;

   assign nxt_remain = start_i ? clocks_i :
                       (remain_ff != '0) ? remain_ff - 1'b1 : remain_ff;
   // each busy sample by the host costs one pass, base cost at first pass
   assign nxt_cost   = start_i ? 16'h0000 :
                       (sample_i && busy_ff && cost_ff == 16'h0000) ? 16'({WAIT_BASE} + {WAIT_PASS}) :
                       (sample_i && busy_ff) ? cost_ff + 16'(WAIT_PASS) : cost_ff;

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         remain_ff <= '0;
         cost_ff   <= 16'h0000;
         busy_ff   <= 1'b0;
      end else begin
         remain_ff <= nxt_remain;
         cost_ff   <= nxt_cost;
         busy_ff   <= (nxt_remain != '0);
      end
   end

   assign busy_o      = busy_ff;
   assign wait_cost_o = cost_ff;

endmodule

// ---- rtl/ned_decoder.sv ----
// numeric escape decoder: decodes two instruction bytes and runs busy
// assumes bytes arrive from same-clock fetch logic; ea time is an input
//
// Functional notes
// - constant loads share prefix; low three bits pick the constant, 11-24 clocks.
// - memory format 00 real32, 01 int32, 10 real64, 11 int16.
// - destination bit 0 writes stack top, 1 writes the entry below.
// - pop bit set pops stack top and adds five clocks.
// - reverse bit swaps subtract/divide operands; destination bit inverts its sense.
// - mode 00 no disp, 01 sign-extended byte, 10 word, 11 register.
// - register/memory code picks base and index registers added to disp.
// - mode 00 with code 110 uses direct word address, not BP.
// - memory arithmetic opcode 000 add, 001 mul, 10R sub, 11R div.
// - register arithmetic ranges: add/sub 70-100, mul 90-145, div 193-203.
// - sqrt 180-186, scale 32-38, remainder 15-190, round 16-50.
// - extract 27-55; magnitude and negate 10-17.
// - transcendental ranges from 30-540 up to 900-1100.
// - init, irq allow/block, exception clear in group 011, 2-8 clocks.
// - control word load 7-14, control/status store 12-18, plus ea.
// - environment store 40-50, load 35-45, plus ea.
// - full state save and restore 197-207, plus ea.
// - stack pointer increment or decrement takes 6-12 clocks.
// - mark entry empty 9-16; idle 10-16.
// - host wait polls test until busy drops; costs 3 plus 5 per pass.
`timescale 1ns/10ps
module ned_decoder
   import ned_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        arst_n_i,
   input  wire logic        instr_valid_i,
   input  wire logic [7:0]  byte0_i,
   input  wire logic [7:0]  byte1_i,
   input  wire logic [7:0]  disp_low_i,
   input  wire logic [7:0]  disp_high_i,
   input  ned_regs_t        regs_i,
   input  wire logic [10:0] ea_clocks_i,
   input  wire logic        host_sample_i,
   output ned_dec_t         dec_o,
   output logic             dec_valid_o,
   output logic             illegal_o,
   output logic             busy_o,
   output logic [15:0]      wait_cost_o
);

   // ****************************************
   // field extraction
   // ****************************************
   wire logic       is_escape = (byte0_i[7:3] == ESC_PREFIX);
   wire logic [2:0] op1       = byte0_i[2:0];
   wire logic [1:0] mode      = byte1_i[7:6];
   wire logic [2:0] mid       = byte1_i[5:3];
   wire logic [2:0] rm        = byte1_i[2:0];
   wire logic       reg_form  = (mode == MOD_REG);

   // ****************************************
   // displacement and effective location
   // ****************************************
   wire logic [15:0] disp16 = {disp_high_i, disp_low_i};
   wire logic [15:0] disp8s = {{8{disp_low_i[7]}}, disp_low_i};
   wire logic [15:0] disp   = (mode == MOD_DISP8)  ? disp8s :
                              (mode == MOD_DISP16) ? disp16 :
                              16'h0000;
   logic [15:0] base_sum;
   always_comb begin
      unique case (rm)
         3'h0: base_sum = regs_i.bx + regs_i.si;
         3'h1: base_sum = regs_i.bx + regs_i.di;
         3'h2: base_sum = regs_i.bp + regs_i.si;
         3'h3: base_sum = regs_i.bp + regs_i.di;
         3'h4: base_sum = regs_i.si;
         3'h5: base_sum = regs_i.di;
         3'h6: base_sum = regs_i.bp;
         3'h7: base_sum = regs_i.bx;
      endcase
   end
   wire logic        direct   = (mode == MOD_NODISP) && (rm == RM_DIRECT);
   wire logic [15:0] location = direct ? disp16 : base_sum + disp;

   // ****************************************
   // operation select
   // ****************************************
   wire logic d_bit = op1[2];
   wire logic p_bit = op1[1];
   logic      arith_reg;
   logic      arith_mem;
   ned_op_t   op;
   logic [10:0] lo;
   logic [10:0] hi;
   logic        ea;

   always_comb begin
      op        = OP_NONE;
      lo        = 11'h000;
      hi        = 11'h000;
      ea        = 1'b0;
      arith_reg = 1'b0;
      arith_mem = 1'b0;
      if (!reg_form && !op1[0]) begin
         arith_mem = 1'b1;
         unique case (mid[2:1])
            2'h0: op = mid[0] ? OP_MUL : OP_ADD;
            2'h1: op = OP_NONE;
            2'h2: op = OP_SUB;
            2'h3: op = OP_DIV;
         endcase
         unique case (op)
            OP_ADD, OP_SUB: begin
               lo = (byte0_i[2:1] == MF_INT32) ? 11'h06C : (byte0_i[2:1] == MF_REAL64) ? 11'h05F : 11'h05A;
               hi = (byte0_i[2:1] == MF_INT32) ? 11'h08F : (byte0_i[2:1] == MF_REAL64) ? 11'h07D : 11'h078;
            end
            OP_MUL: begin
               lo = (byte0_i[2:1] == MF_INT32) ? 11'h082 : (byte0_i[2:1] == MF_REAL64) ? 11'h070 : 11'h06E;
               hi = (byte0_i[2:1] == MF_INT32) ? 11'h090 : (byte0_i[2:1] == MF_REAL64) ? 11'h0A8 : 11'h07D;
            end
            OP_DIV: begin
               lo = (byte0_i[2:1] == MF_INT32) ? 11'h0E6 : (byte0_i[2:1] == MF_REAL64) ? 11'h0DC : 11'h0D7;
               hi = (byte0_i[2:1] == MF_INT32) ? 11'h0F3 : (byte0_i[2:1] == MF_REAL64) ? 11'h0E6 : 11'h0E1;
            end
            default: begin
               lo = 11'h000;
               hi = 11'h000;
            end
         endcase
         ea = (op != OP_NONE);
      end else if (reg_form && op1[0] == 1'b0 && mid[2:1] != 2'h1) begin
         arith_reg = 1'b1;
         unique case (mid)
            3'h0: begin op = OP_ADD; lo = 11'h046; hi = 11'h064; end
            3'h1: begin op = OP_MUL; lo = 11'h05A; hi = 11'h091; end
            3'h4, 3'h5: begin op = OP_SUB; lo = 11'h046; hi = 11'h064; end
            3'h6, 3'h7: begin op = OP_DIV; lo = 11'h0C1; hi = 11'h0CB; end
            default: begin op = OP_NONE; arith_reg = 1'b0; end
         endcase
      end else if (op1 == 3'h1 && reg_form) begin
         unique case (mid)
            3'h2: if (rm == 3'h0) begin op = OP_IDLE; lo = 11'h00A; hi = 11'h010; end
            3'h4: unique case (rm)
               3'h0: begin op = OP_CHS; lo = 11'h00A; hi = 11'h011; end
               3'h1: begin op = OP_ABS; lo = 11'h00A; hi = 11'h011; end
               default: op = OP_NONE;
            endcase
            3'h5: unique case (rm)
               3'h0: begin op = OP_LD1;   lo = 11'h00F; hi = 11'h015; end
               3'h1: begin op = OP_LDL2T; lo = 11'h010; hi = 11'h016; end
               3'h2: begin op = OP_LDL2E; lo = 11'h00F; hi = 11'h015; end
               3'h3: begin op = OP_LDPI;  lo = 11'h010; hi = 11'h016; end
               3'h4: begin op = OP_LDLG2; lo = 11'h012; hi = 11'h018; end
               3'h5: begin op = OP_LDLN2; lo = 11'h011; hi = 11'h017; end
               3'h6: begin op = OP_LDZ;   lo = 11'h00B; hi = 11'h011; end
               default: op = OP_NONE;
            endcase
            3'h6: unique case (rm)
               3'h0: begin op = OP_EXP2M1; lo = 11'h136; hi = 11'h276; end
               3'h1: begin op = OP_YL2X;   lo = 11'h384; hi = 11'h44C; end
               3'h2: begin op = OP_PTAN;   lo = 11'h01E; hi = 11'h21C; end
               3'h3: begin op = OP_PATAN;  lo = 11'h0FA; hi = 11'h320; end
               3'h4: begin op = OP_XTRACT; lo = 11'h01B; hi = 11'h037; end
               3'h6: begin op = OP_DECSP;  lo = 11'h006; hi = 11'h00C; end
               3'h7: begin op = OP_INCSP;  lo = 11'h006; hi = 11'h00C; end
               default: op = OP_NONE;
            endcase
            3'h7: unique case (rm)
               3'h0: begin op = OP_PREM;   lo = 11'h00F; hi = 11'h0BE; end
               3'h1: begin op = OP_YL2XP1; lo = 11'h2BC; hi = 11'h3E8; end
               3'h2: begin op = OP_SQRT;   lo = 11'h0B4; hi = 11'h0BA; end
               3'h4: begin op = OP_RND;    lo = 11'h010; hi = 11'h032; end
               3'h5: begin op = OP_SCALE;  lo = 11'h020; hi = 11'h026; end
               default: op = OP_NONE;
            endcase
            default: op = OP_NONE;
         endcase
      end else if (op1 == 3'h3 && reg_form && mid == 3'h4) begin
         lo = 11'h002;
         hi = 11'h008;
         unique case (rm)
            3'h0: op = OP_IRQON;
            3'h1: op = OP_IRQOFF;
            3'h2: op = OP_CLEX;
            3'h3: op = OP_INIT;
            default: op = OP_NONE;
         endcase
      end else if (op1 == 3'h5 && reg_form && mid == 3'h0) begin
         op = OP_FREE; lo = 11'h009; hi = 11'h010;
      end else if (op1 == 3'h1 && !reg_form) begin
         ea = 1'b1;
         unique case (mid)
            3'h4: begin op = OP_LDENV; lo = 11'h023; hi = 11'h02D; end
            3'h5: begin op = OP_LDCW;  lo = 11'h007; hi = 11'h00E; end
            3'h6: begin op = OP_STENV; lo = 11'h028; hi = 11'h032; end
            3'h7: begin op = OP_STCW;  lo = 11'h00C; hi = 11'h012; end
            default: begin op = OP_NONE; ea = 1'b0; end
         endcase
      end else if (op1 == 3'h5 && !reg_form) begin
         ea = 1'b1;
         unique case (mid)
            3'h4: begin op = OP_RSTOR; lo = 11'h0C5; hi = 11'h0CF; end
            3'h6: begin op = OP_SAVE;  lo = 11'h0C5; hi = 11'h0CF; end
            3'h7: begin op = OP_STSW;  lo = 11'h00C; hi = 11'h012; end
            default: begin op = OP_NONE; ea = 1'b0; end
         endcase
      end
   end

   // ****************************************
   // result assembly
   // ****************************************
   wire logic        pop_now  = arith_reg && p_bit;
   wire logic [10:0] pop_add  = pop_now ? POP_EXTRA : 11'h000;
   wire logic [10:0] ea_add   = ea ? ea_clocks_i : 11'h000;
   wire logic        rev_raw  = mid[0] && (op == OP_SUB || op == OP_DIV);
   wire logic        rev_eff  = rev_raw ^ (arith_reg && d_bit);
   ned_dec_t         nxt_dec;
   always_comb begin
      nxt_dec             = '0;
      nxt_dec.op          = op;
      nxt_dec.mem_format  = arith_mem ? byte0_i[2:1] : MF_REAL32;
      nxt_dec.dest_below  = arith_reg && d_bit;
      nxt_dec.pop         = pop_now;
      nxt_dec.reversed    = (op == OP_SUB || op == OP_DIV) ? rev_eff : 1'b0;
      nxt_dec.mem_operand = ea;
      nxt_dec.stack_index = rm;
      nxt_dec.location    = ea ? location : 16'h0000;
      nxt_dec.min_clocks  = lo + pop_add + ea_add;
      nxt_dec.max_clocks  = hi + pop_add + ea_add;
      nxt_dec.adds_ea     = ea;
   end

   wire logic take    = instr_valid_i && !busy_o;
   wire logic legal   = is_escape && (op != OP_NONE);
   wire logic is_wait = (byte0_i == HOST_WAIT_OP);

   ned_dec_t dec_ff;
   logic     valid_ff;
   logic     illegal_ff;
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         dec_ff     <= '0;
         valid_ff   <= 1'b0;
         illegal_ff <= 1'b0;
      end else begin
         valid_ff   <= take && legal;
         illegal_ff <= take && !legal && !is_wait;
         if (take && legal) begin
            dec_ff <= nxt_dec;
         end
      end
   end

   // ****************************************
   // busy timing
   // ****************************************
   ned_busy_timer #(
      .CNT_W (11)
   ) u_busy (
      .clk_i       (clk_i),
      .arst_n_i    (arst_n_i),
      .start_i     (take && legal),
      .clocks_i    (nxt_dec.max_clocks),
      .sample_i    (host_sample_i),
      .busy_o      (busy_o),
      .wait_cost_o (wait_cost_o)
   );

   assign dec_o       = dec_ff;
   assign dec_valid_o = valid_ff;
   assign illegal_o   = illegal_ff;

endmodule

// ---- tb/ned_decoder_props.sv ----
// checker: timing and field relations at the decoder's top ports
// assumes one clock domain and an async active-low reset
`timescale 1ns/10ps
module ned_decoder_props
   import ned_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        arst_n_i,
   input  wire logic        instr_valid_i,
   input  wire logic [7:0]  byte0_i,
   input  wire logic [7:0]  byte1_i,
   input  wire logic [7:0]  disp_low_i,
   input  wire logic [7:0]  disp_high_i,
   input  ned_regs_t        regs_i,
   input  wire logic [10:0] ea_clocks_i,
   input  wire logic        host_sample_i,
   input  ned_dec_t         dec_o,
   input  wire logic        dec_valid_o,
   input  wire logic        illegal_o,
   input  wire logic        busy_o,
   input  wire logic [15:0] wait_cost_o
);
   // ****************************************
   // properties
   // ****************************************
   default clocking @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   logic [10:0] busy_len_ff;
   logic        take;
   logic        esc;
   logic        arith;
   logic        regf;
   assign take  = instr_valid_i && !busy_o;
   assign esc   = take && (byte0_i[7:3] == ESC_PREFIX);
   assign arith = esc && !byte0_i[0];
   assign regf  = byte1_i[7:6] == MOD_REG;
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) busy_len_ff <= 11'h000;
      else busy_len_ff <= busy_o ? busy_len_ff + 11'h001 : 11'h000;
   end
   esc_answer_a: assert property (esc |=> dec_valid_o ^ illegal_o)
      else $error("escape take without one answer");
   foreign_byte_a: assert property (take && byte0_i[7:3] != ESC_PREFIX && byte0_i != HOST_WAIT_OP
      |=> illegal_o && !dec_valid_o) else $error("foreign byte not flagged");
   wait_quiet_a: assert property (take && byte0_i == HOST_WAIT_OP |=> !(dec_valid_o || illegal_o || busy_o))
      else $error("host wait byte answered");
   busy_refuse_a: assert property (instr_valid_i && busy_o |=> !dec_valid_o && !illegal_o)
      else $error("request taken while busy");
   mem_format_a: assert property (arith && !regf |=> !dec_valid_o
      || (dec_o.mem_format == $past(byte0_i[2:1]) && dec_o.mem_operand)) else $error("memory format wrong");
   reg_fields_a: assert property (arith && regf |=> !dec_valid_o || (dec_o.dest_below == $past(byte0_i[2])
      && dec_o.pop == $past(byte0_i[1]) && dec_o.stack_index == $past(byte1_i[2:0])))
      else $error("register form fields wrong");
   direct_addr_a: assert property (esc && byte1_i[7:6] == MOD_NODISP && byte1_i[2:0] == RM_DIRECT
      |=> !dec_valid_o || dec_o.location == $past({disp_high_i, disp_low_i})) else $error("direct address wrong");
   busy_span_a: assert property ($fell(busy_o) |-> busy_len_ff == dec_o.max_clocks)
      else $error("busy length differs from max clocks");
   busy_floor_a: assert property ($rose(busy_o) |-> busy_o [*8])
      else $error("busy shorter than eight clocks");
   wait_step_a: assert property (host_sample_i && busy_o |=> wait_cost_o ==
      (($past(wait_cost_o) == 16'h0000) ? 16'h0008 : $past(wait_cost_o) + 16'h0005))
      else $error("wait cost step wrong");
   take_cover: cover property (esc ##1 dec_valid_o);
   refuse_cover: cover property (instr_valid_i && busy_o);
   poll_cover: cover property (host_sample_i && busy_o ##1 !busy_o);
endmodule

bind ned_decoder ned_decoder_props ned_decoder_props_inst (
   .clk_i(clk_i), .arst_n_i(arst_n_i), .instr_valid_i(instr_valid_i), .byte0_i(byte0_i),
   .byte1_i(byte1_i), .disp_low_i(disp_low_i), .disp_high_i(disp_high_i), .regs_i(regs_i),
   .ea_clocks_i(ea_clocks_i), .host_sample_i(host_sample_i), .dec_o(dec_o),
   .dec_valid_o(dec_valid_o), .illegal_o(illegal_o), .busy_o(busy_o), .wait_cost_o(wait_cost_o));

// ---- tb/ned_host_model.sv ----
// host model: issues instruction bytes and polls the test line
// assumes the decoder's busy output is registered on clk_i
`timescale 1ns/10ps
module ned_host_model
   import ned_pkg::*;
(
   input  wire logic  clk_i,
   input  wire logic  busy_i,
   output logic       instr_valid_o,
   output logic [7:0] byte0_o,
   output logic [7:0] byte1_o,
   output logic       host_sample_o
);
   // ****************************************
   // issue and poll
   // ****************************************
   logic [2:0] pass_ff = 3'h0;
   initial begin
      instr_valid_o = 1'b0;
      byte0_o       = 8'h00;
      byte1_o       = 8'h00;
      host_sample_o = 1'b0;
   end
   // one request for one edge; released bytes do not keep their value
   task automatic issue(input logic [7:0] b0, input logic [7:0] b1, input logic idle_first);
      @(negedge clk_i);
      while (idle_first && busy_i) @(negedge clk_i);
      instr_valid_o <= 1'b1;
      byte0_o       <= b0;
      byte1_o       <= b1;
      @(negedge clk_i);
      instr_valid_o <= 1'b0;
      byte0_o       <= ~b0;
      byte1_o       <= ~b1;
   endtask
   // one test-line look per five-clock pass while busy
   always @(negedge clk_i) begin
      host_sample_o <= busy_i && (pass_ff == 3'h4);
      pass_ff       <= (!busy_i || pass_ff == 3'h4) ? 3'h0 : pass_ff + 3'h1;
   end
endmodule

// ---- tb/tb_top.sv ----
// self-checking bench for the numeric escape decoder
// assumes the host model drives bytes and polls; bench drives the rest
`timescale 1ns/10ps
module tb_top
   import ned_pkg::*;
;
   // ****************************************
   // bench
   // ****************************************
   logic        clk = 1'b0;
   logic        arst_n = 1'b0;
   logic        instr_valid, host_sample, dec_valid, illegal, busy;
   logic [7:0]  byte0, byte1;
   logic [7:0]  disp_low = 8'hF5;
   logic [7:0]  disp_high = 8'h12;
   logic [10:0] ea_clocks = 11'h00A;
   logic [15:0] wait_cost;
   ned_regs_t   regs = '{16'h1000, 16'h2000, 16'h0300, 16'h0040};
   ned_dec_t    dec;
   int          fail_count = 0;
   int          cmp_count = 0;
   int          cycles = 0;
   ned_op_t     cop [7] = '{OP_LD1, OP_LDL2T, OP_LDL2E, OP_LDPI, OP_LDLG2, OP_LDLN2, OP_LDZ};
   logic [10:0] cmx [7] = '{11'h015, 11'h016, 11'h015, 11'h016, 11'h018, 11'h017, 11'h011};
   logic [10:0] amx [4] = '{11'h082, 11'h099, 11'h087, 11'h000};
   logic [15:0] eab [8] = '{16'h1300, 16'h1040, 16'h2300, 16'h2040, 16'h0300, 16'h0040, 16'h2000, 16'h1000};
   logic [32:0] tbl [27] = '{
      {8'hD9, 8'hFA, OP_SQRT, 11'h0BA}, {8'hD9, 8'hFD, OP_SCALE, 11'h026}, {8'hD9, 8'hF8, OP_PREM, 11'h0BE},
      {8'hD9, 8'hFC, OP_RND, 11'h032}, {8'hD9, 8'hF4, OP_XTRACT, 11'h037}, {8'hD9, 8'hE1, OP_ABS, 11'h011},
      {8'hD9, 8'hE0, OP_CHS, 11'h011}, {8'hD9, 8'hF2, OP_PTAN, 11'h21C}, {8'hD9, 8'hF3, OP_PATAN, 11'h320},
      {8'hD9, 8'hF0, OP_EXP2M1, 11'h276}, {8'hD9, 8'hF1, OP_YL2X, 11'h44C}, {8'hD9, 8'hF9, OP_YL2XP1, 11'h3E8},
      {8'hDB, 8'hE3, OP_INIT, 11'h008}, {8'hDB, 8'hE0, OP_IRQON, 11'h008}, {8'hDB, 8'hE1, OP_IRQOFF, 11'h008},
      {8'hDB, 8'hE2, OP_CLEX, 11'h008}, {8'hD9, 8'h2F, OP_LDCW, 11'h018}, {8'hD9, 8'h3F, OP_STCW, 11'h01C},
      {8'hDD, 8'h3F, OP_STSW, 11'h01C}, {8'hD9, 8'h37, OP_STENV, 11'h03C}, {8'hD9, 8'h27, OP_LDENV, 11'h037},
      {8'hDD, 8'h37, OP_SAVE, 11'h0D9}, {8'hDD, 8'h27, OP_RSTOR, 11'h0D9}, {8'hD9, 8'hF7, OP_INCSP, 11'h00C},
      {8'hD9, 8'hF6, OP_DECSP, 11'h00C}, {8'hDD, 8'hC3, OP_FREE, 11'h010}, {8'hD9, 8'hD0, OP_IDLE, 11'h010}};

   always #12.5 clk = ~clk;

   ned_decoder ned_decoder_inst (
      .clk_i(clk), .arst_n_i(arst_n), .instr_valid_i(instr_valid), .byte0_i(byte0), .byte1_i(byte1),
      .disp_low_i(disp_low), .disp_high_i(disp_high), .regs_i(regs), .ea_clocks_i(ea_clocks),
      .host_sample_i(host_sample), .dec_o(dec), .dec_valid_o(dec_valid), .illegal_o(illegal),
      .busy_o(busy), .wait_cost_o(wait_cost));
   ned_host_model ned_host_model_inst (
      .clk_i(clk), .busy_i(busy), .instr_valid_o(instr_valid), .byte0_o(byte0), .byte1_o(byte1),
      .host_sample_o(host_sample));

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // one instruction: answer, busy span and host wait cost
   task automatic run(input logic [7:0] b0, input logic [7:0] b1, input ned_op_t op, input logic [10:0] mx);
      int n;
      int len;
      n = 0;
      ned_host_model_inst.issue(b0, b1, 1'b1);
      chk("decode pulse", 32'h1, {31'h0, dec_valid});
      chk("operation", {26'h0, op}, {26'h0, dec.op});
      for (len = 0; len < 32'h7D0; len++) begin
         n += int'(host_sample);
         if (busy !== 1'b1) break;
         @(negedge clk);
      end
      if (mx != 11'h000) chk("busy clocks", {21'h0, mx}, len);
      if (mx != 11'h000) chk("max clocks", {21'h0, mx}, {21'h0, dec.max_clocks});
      chk("wait cost", (n == 0) ? 32'h0 : 32'h3 + 32'h5 * n, {16'h0, wait_cost});
   endtask

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 32'h4E20) begin
         fail_count++;
         give_verdict();
      end
   end

   initial begin
      repeat (2) @(negedge clk);
      arst_n = 1'b1;
      for (int k = 0; k < 7; k++) run(8'hD9, {5'h1D, k[2:0]}, cop[k], cmx[k]);
      $display("constant loads done");
      for (int k = 0; k < 4; k++) begin
         run({5'h1B, k[1:0], 1'b0}, 8'h07, OP_ADD, amx[k]);
         chk("format", k, {30'h0, dec.mem_format});
         chk("memory operand", 32'h1, {31'h0, dec.mem_operand});
      end
      run(8'hD8, 8'h2F, OP_SUB, 11'h082);
      chk("reverse", 32'h1, {31'h0, dec.reversed});
      run(8'hD8, 8'h0F, OP_MUL, 11'h087);
      run(8'hD8, 8'h37, OP_DIV, 11'h0EB);
      chk("reverse", 32'h0, {31'h0, dec.reversed});
      $display("memory arithmetic done");
      for (int k = 0; k < 4; k++) begin
         run({5'h1B, k[1:0], 1'b0}, 8'hEB, OP_SUB, 11'h064 + (k[0] ? 11'h005 : 11'h000));
         chk("destination", {31'h0, k[1]}, {31'h0, dec.dest_below});
         chk("pop", {31'h0, k[0]}, {31'h0, dec.pop});
         chk("min clocks", {21'h0, 11'h046 + (k[0] ? 11'h005 : 11'h000)}, {21'h0, dec.min_clocks});
         chk("reverse", {31'h0, !k[1]}, {31'h0, dec.reversed});
         chk("stack index", 32'h3, {29'h0, dec.stack_index});
      end
      run(8'hD8, 8'hC2, OP_ADD, 11'h064);
      run(8'hD8, 8'hCA, OP_MUL, 11'h091);
      run(8'hD8, 8'hF9, OP_DIV, 11'h0CB);
      $display("register arithmetic done");
      for (int k = 0; k < 8; k++) begin
         run(8'hD9, {5'h15, k[2:0]}, OP_LDCW, 11'h018);
         chk("address", {16'h0, eab[k]} + 32'h12F5, {16'h0, dec.location});
         chk("ea added", 32'h1, {31'h0, dec.adds_ea});
      end
      run(8'hD9, 8'h6F, OP_LDCW, 11'h018);
      chk("address", 32'h0FF5, {16'h0, dec.location});
      run(8'hD9, 8'h28, OP_LDCW, 11'h018);
      chk("address", 32'h1300, {16'h0, dec.location});
      run(8'hD9, 8'h2E, OP_LDCW, 11'h018);
      chk("address", 32'h12F5, {16'h0, dec.location});
      $display("addressing done");
      for (int k = 0; k < 27; k++) run(tbl[k][32:25], tbl[k][24:17], ned_op_t'(tbl[k][16:11]), tbl[k][10:0]);
      $display("operation table done");
      ned_host_model_inst.issue(8'hD9, 8'hE8, 1'b1);
      ned_host_model_inst.issue(8'h00, 8'h00, 1'b0);
      chk("refused", 32'h0, {30'h0, dec_valid, illegal});
      ned_host_model_inst.issue(8'h00, 8'h00, 1'b1);
      chk("illegal", 32'h1, {30'h0, dec_valid, illegal});
      chk("held decode", {26'h0, OP_LD1}, {26'h0, dec.op});
      ned_host_model_inst.issue(8'hD8, 8'h17, 1'b1);
      chk("unlisted memory op", 32'h1, {30'h0, dec_valid, illegal});
      ned_host_model_inst.issue(HOST_WAIT_OP, 8'h00, 1'b1);
      chk("host wait byte", 32'h0, {29'h0, dec_valid, illegal, busy});
      $display("refusal and foreign bytes done");
      give_verdict();
   end
endmodule
